// file: src/egmp_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module egmp_pin_sync (
    // clock and reset
    input logic ref_clk,
    input logic srst,
    // pin bundle
    egmp_sync_if.sync pins
);
    genvar i;
    generate
        for (i = 0; i < egmp_pkg::SYNC_W; i = i + 1) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic clean_reg;
            // stage one feeds only stage two; change taken once two and three agree
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    clean_reg <= 1'b0;
                end else begin
                    s1_reg <= pins.raw[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        clean_reg <= s3_reg;
                    end
                end
            end
            assign pins.clean[i] = clean_reg;
        end
    endgenerate
endmodule

// file: src/egmp_pkg.sv
// constants shared by the external media-independent port logic
package egmp_pkg;
    // reference clock rate and derived transmit clock divider
    localparam int CLK_MHZ = 10;
    localparam int GTX_HALF_NS = 4; // half period of the 125 MHz transmit clock
    localparam int GTX_HALF_RAW = GTX_HALF_NS * CLK_MHZ / 1000;
    localparam int GTX_HALF_CYC = (GTX_HALF_RAW < 1) ? 1 : GTX_HALF_RAW;
    localparam logic [3:0] GTX_LAST = 4'(GTX_HALF_CYC - 1);
    localparam logic [3:0] GTX_CNT_RST = 4'h0;
    // strap sampling after reset release, covers the synchroniser latency
    localparam logic [2:0] STRAP_SETTLE_LAST = 3'h5;
    localparam logic [2:0] STRAP_CNT_RST = 3'h0;
    // transmit octet sent during carrier extension
    localparam logic [7:0] CARRIER_EXT_CODE = 8'h0F;
    localparam logic [7:0] OCTET_RST = 8'h00;
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    // bit positions inside the synchronised pin bundle
    localparam int SYNC_W = 17;
    localparam int SB_RXCLK = 0;
    localparam int SB_TXCLK = 1;
    localparam int SB_DV = 2;
    localparam int SB_ER = 3;
    localparam int SB_COL = 4;
    localparam int SB_CRS = 5;
    localparam int SB_LINK_INDICATION_IN = 6;
    localparam int SB_STRAP_HI = 7;
    localparam int SB_STRAP_LO = 8;
    localparam int SB_RXD_LSB = 9;
    // nibble phase of the slow-mode datapath
    typedef enum logic [0:0] {
        EGMP_NIB_LO = 1'b0,
        EGMP_NIB_HI = 1'b1
    } egmp_nib_t;
endpackage

// file: src/egmp_port.sv
// external gigabit / 10-100 media-independent port, MAC side
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - internal MAC/PHY interface can be routed out to an external GMII/MII device
// RULE2 - strap high-then-low pattern, sampled after reset, enables external operation
// RULE3 - gigabit transmit octets go out on the eight-bit data bus
// RULE4 - transmit enable high exactly while valid transmit data is on the bus
// RULE5 - gigabit transmit error flag propagates errors; with enable low, marks extension
// RULE6 - slow mode sends nibbles on low four bits; error output stays unused
// RULE7 - gigabit receive octets are taken from the eight-bit receive bus
// RULE8 - far end raises data-valid for frame data; data taken only while valid high
// RULE9 - receive error from far end marks the current frame as errored
// RULE10 - slow mode takes nibbles from low four receive bits, still valid-qualified
// RULE11 - collision input gives half-duplex collision indication in both modes
// RULE12 - carrier-sense input gives half-duplex carrier indication in both modes
// RULE13 - link-up state follows the far end's link indication input
// RULE14 - management interface unavailable while in external gigabit mode
// RULE15 - far end supplies the slow-mode receive clock
// RULE16 - far end supplies the slow-mode transmit clock, unused in gigabit mode
// RULE17 - gigabit mode sources the transmit clock and launches transmit signals on it
// RULE18 - far end supplies the gigabit receive clock
module egmp_port (
    // clock and reset
    input logic ref_clk,
    input logic srst,
    // mode straps and speed choice
    input logic ext_port_strap_high,
    input logic ext_port_strap_low,
    input logic gigModeSel,
    // transmit stream from the MAC
    input logic [7:0] txByte,
    input logic txValid,
    input logic txError,
    input logic txExtend,
    output logic txReady,
    // receive stream to the MAC
    output logic [7:0] rxByte,
    output logic rxByteValid,
    output logic rxFrameEnd,
    output logic rxFrameErr,
    // status to the MAC
    output logic extModeOn,
    output logic mgmtAvail,
    output logic collision,
    output logic carrierSense,
    output logic linkUp,
    // transmit pins
    output logic [7:0] txDataPin,
    output logic txEnPin,
    output logic txErPin,
    output logic gtxClkPin,
    // receive and status pins
    input logic rxClkPin,
    input logic slow_link_transmit_clock,
    input logic [7:0] rxDataPin,
    input logic rxDvPin,
    input logic rxErPin,
    input logic colPin,
    input logic crsPin,
    input logic link_indication_in
);
    egmp_sync_if syncIf();

    // all far-end pins cross into ref_clk together so data stays aligned with its clock
    assign syncIf.raw = {rxDataPin, ext_port_strap_low, ext_port_strap_high,
                         link_indication_in, crsPin, colPin, rxErPin, rxDvPin,
                         slow_link_transmit_clock, rxClkPin};

    egmp_pin_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .pins(syncIf.sync)
    );

    // named views of the synchronised bundle
    wire rxClkC = syncIf.clean[egmp_pkg::SB_RXCLK];
    wire txClkC = syncIf.clean[egmp_pkg::SB_TXCLK];
    wire rxDvC = syncIf.clean[egmp_pkg::SB_DV];
    wire rxErC = syncIf.clean[egmp_pkg::SB_ER];
    wire colC = syncIf.clean[egmp_pkg::SB_COL];
    wire crsC = syncIf.clean[egmp_pkg::SB_CRS];
    wire lindC = syncIf.clean[egmp_pkg::SB_LINK_INDICATION_IN];
    wire strapHiC = syncIf.clean[egmp_pkg::SB_STRAP_HI];
    wire strapLoC = syncIf.clean[egmp_pkg::SB_STRAP_LO];
    wire [7:0] rxDataC = syncIf.clean[egmp_pkg::SB_RXD_LSB +: 8];

    logic rxClkPrev_reg;
    logic txClkPrev_reg;
    logic [2:0] strapCnt_reg;
    logic strapDone_reg;
    logic extMode_reg;
    logic gig_reg;
    logic [3:0] gtxCnt_reg;
    logic gtxClk_reg;
    logic [7:0] txData_reg;
    logic txEn_reg;
    logic txEr_reg;
    egmp_pkg::egmp_nib_t txPhase_reg;
    logic [7:0] rxByte_reg;
    logic rxByteValid_reg;
    logic [3:0] rxLowNib_reg;
    egmp_pkg::egmp_nib_t rxHalf_reg;
    logic rxInFrame_reg;
    logic rxErrFlag_reg;
    logic rxEnd_reg;
    logic rxEndErr_reg;
    logic col_reg;
    logic crs_reg;
    logic link_reg;
    logic mgmt_reg;

    // edge finding and launch selection
    wire active = extMode_reg;
    wire rxEdge = rxClkC && !rxClkPrev_reg;
    wire txSlowEdge = txClkC && !txClkPrev_reg; // RULE16
    wire gtxTick = (gtxCnt_reg == egmp_pkg::GTX_LAST);
    wire gtxFall = gtxTick && gtxClk_reg;
    wire launch = active && (gig_reg ? gtxFall : txSlowEdge); // RULE17
    wire strapPattern = strapHiC && !strapLoC;

    // byte taken in gigabit on every launch, in slow mode on the high nibble
    assign txReady = launch && (gig_reg || (txPhase_reg == egmp_pkg::EGMP_NIB_HI));

    // strap capture once the synchroniser has settled; held until next reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strapCnt_reg <= egmp_pkg::STRAP_CNT_RST;
            strapDone_reg <= 1'b0;
            extMode_reg <= 1'b0;
        end else if (!strapDone_reg) begin
            strapCnt_reg <= strapCnt_reg + 3'h1;
            if (strapCnt_reg == egmp_pkg::STRAP_SETTLE_LAST) begin
                extMode_reg <= strapPattern; // RULE1 RULE2
                strapDone_reg <= 1'b1;
            end
        end
    end

    // transmit clock divider, stopped low outside gigabit external mode
    always_ff @(posedge ref_clk) begin
        if (srst || !active || !gig_reg) begin
            gtxCnt_reg <= egmp_pkg::GTX_CNT_RST;
            gtxClk_reg <= 1'b0;
        end else if (gtxTick) begin
            gtxCnt_reg <= egmp_pkg::GTX_CNT_RST;
            gtxClk_reg <= !gtxClk_reg; // RULE17
        end else begin
            gtxCnt_reg <= gtxCnt_reg + 4'h1;
        end
    end

    // transmit pins change on the falling gigabit transmit edge, or in slow mode on the seen rising edge of the far end's transmit clock
    always_ff @(posedge ref_clk) begin
        if (srst || !active) begin
            txData_reg <= egmp_pkg::OCTET_RST;
            txEn_reg <= 1'b0;
            txEr_reg <= 1'b0;
            txPhase_reg <= egmp_pkg::EGMP_NIB_LO;
        end else if (launch && gig_reg) begin
            txPhase_reg <= egmp_pkg::EGMP_NIB_LO;
            if (txValid) begin
                txData_reg <= txByte; // RULE3
                txEn_reg <= 1'b1; // RULE4
                txEr_reg <= txError; // RULE5
            end else if (txExtend) begin
                txData_reg <= egmp_pkg::CARRIER_EXT_CODE;
                txEn_reg <= 1'b0;
                txEr_reg <= 1'b1; // RULE5
            end else begin
                txData_reg <= egmp_pkg::OCTET_RST;
                txEn_reg <= 1'b0;
                txEr_reg <= 1'b0;
            end
        end else if (launch) begin
            txEr_reg <= 1'b0; // RULE6
            case (txPhase_reg)
                egmp_pkg::EGMP_NIB_HI: begin
                    txData_reg <= {egmp_pkg::NIBBLE_RST, txByte[7:4]}; // RULE6
                    txEn_reg <= 1'b1; // RULE4
                    txPhase_reg <= egmp_pkg::EGMP_NIB_LO;
                end
                default: begin
                    txData_reg <= {egmp_pkg::NIBBLE_RST, txValid ? txByte[3:0] : 4'h0};
                    txEn_reg <= txValid; // RULE4
                    txPhase_reg <= txValid ? egmp_pkg::EGMP_NIB_HI : egmp_pkg::EGMP_NIB_LO;
                end
            endcase
        end
    end

    // receive sampling on the far end's clock, seen as a rising edge in ref_clk
    always_ff @(posedge ref_clk) begin
        if (srst || !active) begin
            rxByte_reg <= egmp_pkg::OCTET_RST;
            rxByteValid_reg <= 1'b0;
            rxLowNib_reg <= egmp_pkg::NIBBLE_RST;
            rxHalf_reg <= egmp_pkg::EGMP_NIB_LO;
            rxInFrame_reg <= 1'b0;
            rxErrFlag_reg <= 1'b0;
            rxEnd_reg <= 1'b0;
            rxEndErr_reg <= 1'b0;
        end else begin
            rxByteValid_reg <= 1'b0;
            rxEnd_reg <= 1'b0;
            if (rxEdge && rxDvC) begin // RULE8 RULE15 RULE18
                rxInFrame_reg <= 1'b1;
                if (rxErC) begin
                    rxErrFlag_reg <= 1'b1; // RULE9
                end
                if (gig_reg) begin
                    rxByte_reg <= rxDataC; // RULE7
                    rxByteValid_reg <= 1'b1;
                end else if (rxHalf_reg == egmp_pkg::EGMP_NIB_HI) begin
                    rxByte_reg <= {rxDataC[3:0], rxLowNib_reg}; // RULE10
                    rxByteValid_reg <= 1'b1;
                    rxHalf_reg <= egmp_pkg::EGMP_NIB_LO;
                end else begin
                    rxLowNib_reg <= rxDataC[3:0]; // RULE10
                    rxHalf_reg <= egmp_pkg::EGMP_NIB_HI;
                end
            end else if (rxEdge && rxInFrame_reg) begin
                // an odd trailing nibble is dropped here
                rxInFrame_reg <= 1'b0;
                rxEnd_reg <= 1'b1;
                rxEndErr_reg <= rxErrFlag_reg; // RULE9
                rxErrFlag_reg <= 1'b0;
                rxHalf_reg <= egmp_pkg::EGMP_NIB_LO;
            end
        end
    end

    // edge history, speed choice and half-duplex / link status
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxClkPrev_reg <= 1'b0;
            txClkPrev_reg <= 1'b0;
            gig_reg <= 1'b0;
            col_reg <= 1'b0;
            crs_reg <= 1'b0;
            link_reg <= 1'b0;
            mgmt_reg <= 1'b1;
        end else begin
            rxClkPrev_reg <= rxClkC;
            txClkPrev_reg <= txClkC;
            gig_reg <= gigModeSel;
            col_reg <= active && colC; // RULE11
            crs_reg <= active && crsC; // RULE12
            link_reg <= active && lindC; // RULE13
            mgmt_reg <= !(active && gig_reg); // RULE14
        end
    end

    // pin and user outputs other than txReady, all from flip-flops
    assign txDataPin = txData_reg;
    assign txEnPin = txEn_reg;
    assign txErPin = txEr_reg;
    assign gtxClkPin = gtxClk_reg;
    assign rxByte = rxByte_reg;
    assign rxByteValid = rxByteValid_reg;
    assign rxFrameEnd = rxEnd_reg;
    assign rxFrameErr = rxEndErr_reg;
    assign extModeOn = extMode_reg;
    assign mgmtAvail = mgmt_reg;
    assign collision = col_reg;
    assign carrierSense = crs_reg;
    assign linkUp = link_reg;

    // checks on the block's own outputs and its receive error flag
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_gig_data;
        launch && gig_reg && txValid;
    endsequence
    sequence s_rx_err_seen;
        active && rxEdge && rxDvC && rxErC;
    endsequence

    property p_strap_latch;
        $rose(strapDone_reg) |-> extMode_reg == $past(strapPattern);
    endproperty
    a_strap_latch: assert property (p_strap_latch) else $error("strap not latched"); // RULE2

    property p_idle_off;
        !extMode_reg |-> !txEnPin && !txErPin && !gtxClkPin;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("pins active off mode"); // RULE1

    property p_gig_tx;
        s_gig_data |=> txEnPin && txDataPin == $past(txByte) && txErPin == $past(txError);
    endproperty
    a_gig_tx: assert property (p_gig_tx) else $error("gigabit octet not launched"); // RULE3

    property p_tx_hold;
        (active && txEnPin && !launch) |=> $stable(txDataPin) && txEnPin;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx changed between edges"); // RULE4

    property p_extend;
        (launch && gig_reg && !txValid && txExtend) |=> !txEnPin && txErPin;
    endproperty
    a_extend: assert property (p_extend) else $error("carrier extension wrong"); // RULE5

    property p_mii_tx;
        (launch && !gig_reg) |=> txDataPin[7:4] == 4'h0 && !txErPin;
    endproperty
    a_mii_tx: assert property (p_mii_tx) else $error("slow mode used high bits"); // RULE6

    property p_rx_valid;
        rxByteValid |-> $past(rxDvC) && $past(rxEdge);
    endproperty
    a_rx_valid: assert property (p_rx_valid) else $error("byte without data valid"); // RULE8

    property p_rx_err;
        s_rx_err_seen |=> rxErrFlag_reg;
    endproperty
    a_rx_err: assert property (p_rx_err) else $error("receive error not held"); // RULE9

    property p_mii_rx;
        (active && rxEdge && rxDvC && !gig_reg && rxHalf_reg == egmp_pkg::EGMP_NIB_HI)
            |=> rxByteValid && rxByte == {$past(rxDataC[3:0]), $past(rxLowNib_reg)};
    endproperty
    a_mii_rx: assert property (p_mii_rx) else $error("nibble pairing wrong"); // RULE10

    property p_status;
        active |=> collision == $past(colC) && carrierSense == $past(crsC)
            && linkUp == $past(lindC);
    endproperty
    a_status: assert property (p_status) else $error("status lost"); // RULE11 RULE12 RULE13

    property p_mgmt;
        (active && gig_reg) |=> !mgmtAvail;
    endproperty
    a_mgmt: assert property (p_mgmt) else $error("management left on"); // RULE14

    property p_gtx;
        (active && gig_reg && $past(active && gig_reg) && gtxTick)
            |=> gtxClkPin != $past(gtxClkPin);
    endproperty
    a_gtx: assert property (p_gtx) else $error("transmit clock stalled"); // RULE17
endmodule

// file: src/egmp_sync_if.sv
// bundle of raw pins and their synchronised copies
`timescale 1ns/10ps
interface egmp_sync_if;
    logic [egmp_pkg::SYNC_W-1:0] raw;
    logic [egmp_pkg::SYNC_W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// file: tb/egmp_phy_model.sv
// far-end media-independent device model: clocks, receive frames, status, nibble capture
`timescale 1ns/10ps
module egmp_phy_model (
    // transmit pins from the port
    input wire logic [7:0] txDataPin,
    input wire logic txEnPin,
    input wire logic txErPin,
    // clocks and receive pins toward the port
    output logic rxClkPin,
    output logic slowTxClk,
    output logic [7:0] rxDataPin,
    output logic rxDvPin,
    output logic rxErPin,
    // status pins
    output logic colPin,
    output logic crsPin,
    output logic linkInd
);
    logic txClkOn = 1'b0;
    logic [7:0] txGotQ[$];
    logic [3:0] lowNib;
    int nibCnt = 0;
    int slowBad = 0;

    // everything idle, data lines parked on a non-zero pattern
    initial begin
        {rxClkPin, slowTxClk, rxDvPin, rxErPin, colPin, crsPin, linkInd} = '0;
        rxDataPin = 8'hA5;
    end

    // slow transmit clock, still outside the windows the bench opens
    always begin
        #400;
        slowTxClk = txClkOn ? ~slowTxClk : 1'b0;
    end

    // nibble capture on the rising edge, low half of each byte first
    always @(posedge slowTxClk) begin
        if (txEnPin) begin
            if (txDataPin[7:4] !== 4'h0 || txErPin !== 1'b0) slowBad++;
            if (nibCnt == 0) lowNib = txDataPin[3:0];
            else txGotQ.push_back({txDataPin[3:0], lowNib});
            nibCnt = 1 - nibCnt;
        end else begin
            nibCnt = 0;
        end
    end

    // one frame; data changes with the clock low, trailing edge carries valid low
    task automatic send_frame(input logic [7:0] d[$], input bit nib, input int errAt,
                              input bit trailEr);
        logic [3:0] u;
        int i;
        for (i = 0; i < d.size() * (nib ? 2 : 1); i++) begin
            rxClkPin = 1'b0;
            u = (i % 2) ? d[i/2][7:4] : d[i/2][3:0];
            rxDataPin = nib ? {~u, u} : d[i]; // upper half carries the inverted nibble in nibble mode
            rxDvPin = 1'b1;
            rxErPin = (i == errAt);
            #400 rxClkPin = 1'b1;
            #400;
        end
        rxClkPin = 1'b0;
        rxDvPin = 1'b0;
        rxErPin = trailEr;
        rxDataPin = ~rxDataPin;
        #400 rxClkPin = 1'b1;
        #400 rxClkPin = 1'b0;
        rxErPin = 1'b0;
        rxDataPin = ~rxDataPin;
    endtask

    // collision, carrier and link levels
    task automatic set_status(input logic c, input logic s, input logic l);
        colPin = c;
        crsPin = s;
        linkInd = l;
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the external media-independent port
`timescale 1ns/10ps
module tb;
    // stimulus and design pins
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic strapHi = 1'b1;
    logic strapLo = 1'b0;
    logic gigModeSel = 1'b1;
    logic [7:0] txByte = 8'h00;
    logic txValid = 1'b0;
    logic txError = 1'b0;
    logic txExtend = 1'b0;
    logic txReady, rxByteValid, rxFrameEnd, rxFrameErr, extModeOn, mgmtAvail;
    logic collision, carrierSense, linkUp, txEnPin, txErPin, gtxClkPin;
    logic rxClkPin, slowTxClk, rxDvPin, rxErPin, colPin, crsPin, linkInd;
    logic [7:0] rxByte, txDataPin, rxDataPin;
    // bench state
    int num_errors = 0;
    int tests_run = 0;
    int endCnt = 0;
    bit gigChk = 1'b0;
    bit pend = 1'b0;
    logic [8:0] expTx;
    logic [7:0] expQ[$];
    logic [7:0] rxGotQ[$];

    always #50 ref_clk = ~ref_clk;

    egmp_port uut (.ref_clk(ref_clk), .srst(srst), .ext_port_strap_high(strapHi),
        .ext_port_strap_low(strapLo), .gigModeSel(gigModeSel), .txByte(txByte),
        .txValid(txValid), .txError(txError), .txExtend(txExtend), .txReady(txReady),
        .rxByte(rxByte), .rxByteValid(rxByteValid), .rxFrameEnd(rxFrameEnd),
        .rxFrameErr(rxFrameErr), .extModeOn(extModeOn), .mgmtAvail(mgmtAvail),
        .collision(collision), .carrierSense(carrierSense), .linkUp(linkUp),
        .txDataPin(txDataPin), .txEnPin(txEnPin), .txErPin(txErPin), .gtxClkPin(gtxClkPin),
        .rxClkPin(rxClkPin), .slow_link_transmit_clock(slowTxClk), .rxDataPin(rxDataPin),
        .rxDvPin(rxDvPin), .rxErPin(rxErPin), .colPin(colPin), .crsPin(crsPin),
        .link_indication_in(linkInd));

    egmp_phy_model phy (.txDataPin(txDataPin), .txEnPin(txEnPin), .txErPin(txErPin),
        .rxClkPin(rxClkPin), .slowTxClk(slowTxClk), .rxDataPin(rxDataPin),
        .rxDvPin(rxDvPin), .rxErPin(rxErPin), .colPin(colPin), .crsPin(crsPin),
        .linkInd(linkInd));

    task automatic chk_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard at 30000 cycles, well past the several hundred cycles the tests need
    initial begin
        #3000000;
        num_errors++;
        print_verdict();
    end

    // result monitor: a gigabit byte taken in one cycle must stand on the pins in the next
    always @(negedge ref_clk) begin
        if (pend) begin
            chk_byte("tx octet", expTx[7:0], txDataPin);
            chk_bit("tx enable", 1'b1, txEnPin);
            chk_bit("tx error", expTx[8], txErPin);
        end
        pend = gigChk && txValid && txReady;
        expTx = {txError, txByte};
        if (rxByteValid) rxGotQ.push_back(rxByte);
        if (rxFrameEnd) endCnt++;
    end

    // inputs other than the slow transmit clock move a fixed 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, num_errors);
    endtask

    task automatic do_reset(input logic hi, input logic lo);
        strapHi = hi;
        strapLo = lo;
        srst = 1'b1;
        tick(8);
        chk_bit("mgmt in reset", 1'b1, mgmtAvail);
        chk_bit("tx enable in reset", 1'b0, txEnPin);
        srst = 1'b0;
        tick(12);
    endtask

    // byte held until the consuming edge; back-to-back calls keep valid high
    task automatic send_byte(input logic [7:0] b, input logic e);
        int n;
        txByte = b;
        txError = e;
        txValid = 1'b1;
        expQ.push_back(b);
        for (n = 0; n < 100; n++) begin
            @(negedge ref_clk);
            if (txReady === 1'b1) break;
        end
        if (n == 100) chk_bit("tx ready", 1'b1, 1'b0);
        tick(1);
    endtask

    task automatic rx_frame(input bit nib, input int n, input int errAt, input bit trailEr);
        logic [7:0] d[$];
        int i;
        int e0;
        rxGotQ.delete();
        e0 = endCnt;
        for (i = 0; i < n; i++) d.push_back(8'($urandom));
        phy.send_frame(d, nib, errAt, trailEr);
        tick(12);
        chk_byte("rx count", 8'(n), 8'(rxGotQ.size()));
        for (i = 0; i < n; i++)
            chk_byte("rx octet", d[i], i < rxGotQ.size() ? rxGotQ[i] : 8'hXX);
        chk_byte("frame ends", 8'(e0 + 1), 8'(endCnt));
        chk_bit("frame error", errAt >= 0, rxFrameErr);
    endtask

    task automatic status_check(input logic on);
        int k;
        for (k = 0; k < 3; k++) begin
            phy.set_status(k[0], k[1], ~k[0]);
            tick(8);
            chk_bit("collision", on & k[0], collision);
            chk_bit("carrier", on & k[1], carrierSense);
            chk_bit("link", on & ~k[0], linkUp);
        end
    endtask

    task automatic gtx_check(input logic on);
        int k;
        int t;
        t = 0;
        for (k = 0; k < 10; k++) begin
            @(negedge ref_clk);
            if (gtxClkPin === 1'b1) t++;
        end
        chk_byte("gtx high cycles", on ? 8'h05 : 8'h00, 8'(t));
        tick(1);
    endtask

    initial begin
        int k;
        void'($urandom(48955));
        do_reset(1'b1, 1'b0);
        chk_bit("external mode", 1'b1, extModeOn);
        chk_bit("mgmt gigabit", 1'b0, mgmtAvail);
        gtx_check(1'b1);
        status_check(1'b1);
        end_test("gigabit setup");
        gigChk = 1'b1;
        for (k = 0; k < 6; k++) send_byte(8'($urandom), k == 2);
        txValid = 1'b0;
        txError = 1'b0;
        tick(4);
        chk_bit("idle enable", 1'b0, txEnPin);
        chk_bit("idle error", 1'b0, txErPin);
        txExtend = 1'b1;
        tick(4);
        chk_bit("ext enable", 1'b0, txEnPin);
        chk_bit("ext error", 1'b1, txErPin);
        chk_byte("ext octet", 8'h0F, txDataPin);
        txExtend = 1'b0;
        gigChk = 1'b0;
        tick(4);
        end_test("gigabit transmit");
        rx_frame(1'b0, 6, -1, 1'b1);
        rx_frame(1'b0, 5, 2, 1'b0);
        end_test("gigabit receive");
        gigModeSel = 1'b0;
        tick(4);
        chk_bit("mgmt slow", 1'b1, mgmtAvail);
        gtx_check(1'b0);
        status_check(1'b1);
        rx_frame(1'b1, 4, 5, 1'b0);
        rx_frame(1'b1, 3, -1, 1'b1);
        end_test("slow receive");
        expQ.delete();
        phy.txClkOn = 1'b1;
        for (k = 0; k < 4; k++) send_byte(8'($urandom), k == 1);
        txValid = 1'b0;
        txError = 1'b0;
        tick(40);
        phy.txClkOn = 1'b0;
        chk_byte("slow tx count", 8'(expQ.size()), 8'(phy.txGotQ.size()));
        for (k = 0; k < expQ.size(); k++)
            chk_byte("slow tx octet", expQ[k], phy.txGotQ[k]);
        chk_byte("slow tx upper or error", 8'h00, 8'(phy.slowBad));
        end_test("slow transmit");
        do_reset(1'b1, 1'b1);
        chk_bit("external mode off", 1'b0, extModeOn);
        txValid = 1'b1;
        for (k = 0; k < 20; k++) begin
            @(negedge ref_clk);
            chk_bit("ready refused", 1'b0, txReady);
        end
        tick(1);
        txValid = 1'b0;
        chk_bit("tx enable refused", 1'b0, txEnPin);
        status_check(1'b0);
        end_test("wrong straps");
        print_verdict();
    end
endmodule
